/* File: bench/epd_monitor.sv */
// Concurrent checks for the request pin detector, bound to its top.
// Assumes the package register map and one clock with a sync reset.
`timescale 1ns/10ps

module epd_monitor (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        reset,
  // Pin side and request outputs.
  input wire logic        req_pin,
  input wire logic        pull_up_en,
  input wire logic        pull_down_en,
  input wire logic        cpu_req,
  // Register bus signals that move control writes.
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  // Register bus signals of the read path.
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid
);
  logic [6:0] ctrl_q;  // Shadow of the stored control bits.
  logic       aw_q;    // Write address taken.
  logic       w_q;     // Write data taken.
  logic [7:0] wa_q;    // Taken write address.
  logic [7:0] ra_q;    // Taken read address.
  logic [8:0] wd_q;    // Taken low data byte and lane strobe.
  wire        rise_ok = ctrl_q[4] && ctrl_q[1] && ctrl_q[5];  // Rising, enabled, gated on.
  wire        lvl_ok  = rise_ok && ctrl_q[0] && req_pin;       // Level mode, pin asserted.

  // The shadow strokes one edge after the later half, as the slave does.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q <= 7'h00;
      aw_q   <= 1'b0;
      w_q    <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        wa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q  <= 1'b1;
        wd_q <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
      end
      if (aw_q && w_q) begin
        aw_q <= 1'b0;
        w_q  <= 1'b0;
        // Only the control word at offset zero with its low lane enabled counts.
        if (wa_q[7:2] == 6'h00 && wd_q[8]) begin
          ctrl_q <= {wd_q[6:4], 2'h0, wd_q[1:0]};
        end
      end
      if (s_axi_arvalid && s_axi_arready) begin
        ra_q <= s_axi_araddr;
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // A rising pin seen while enabled and gated on.
  sequence pin_rise_s;
    rise_ok && $rose(req_pin);
  endsequence
  // Pin held at its active level in level mode.
  sequence lvl_held_s;
    lvl_ok [*5];
  endsequence

  pull_excl_a: assert property (!(pull_up_en && pull_down_en))
    else $error("both pulls on");
  pull_up_a: assert property ((ctrl_q == $past(ctrl_q)) |->
    pull_up_en == (ctrl_q[4] && !ctrl_q[6] && !ctrl_q[5])) else $error("pull up wrong");
  pull_down_a: assert property ((ctrl_q == $past(ctrl_q)) |->
    pull_down_en == (ctrl_q[4] && !ctrl_q[6] && ctrl_q[5])) else $error("pull down wrong");
  cpu_gate_a: assert property (!ctrl_q[1] && !$past(ctrl_q[1]) |-> !cpu_req)
    else $error("request while gated off");
  edge_set_a: assert property (pin_rise_s |-> ##[1:4] cpu_req)
    else $error("edge not flagged");
  level_hold_a: assert property (lvl_held_s |-> cpu_req)
    else $error("flag cleared at level");
  pin_off_a: assert property (ctrl_q[1] && !ctrl_q[4] && ctrl_q == $past(ctrl_q)
    && !cpu_req |=> !cpu_req) else $error("event while disabled");
  ack_zero_a: assert property (s_axi_rvalid && ra_q[7:2] == 6'h00 |->
    s_axi_rdata[2] == 1'b0 && s_axi_rdata[31:7] == 25'h0) else $error("ack bit read");
endmodule

bind epd_top epd_monitor u_mon (.core_clk(core_clk), .reset(reset), .req_pin(req_pin),
  .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .cpu_req(cpu_req),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid));

/* File: bench/epd_pin_model.sv */
// Behavioural external device on the request pin.
// Assumes the pad pulls act only when the device lets go of the pin.
`timescale 1ns/10ps

module epd_pin_model (
  // Commands from the bench.
  input wire logic drv_en,
  input wire logic drv_val,
  // Pad pulls seen from the block.
  input wire logic pull_up_en,
  input wire logic pull_down_en,
  // The pin itself.
  output logic     req_pin
);
  initial req_pin = 1'b0;

  // The pin moves 7 ns after a command so it never lines up with the clock.
  // pull sets level
  always @(drv_en or drv_val or pull_up_en or pull_down_en) begin
    #7;
    if (drv_en) begin
      req_pin = drv_val;
    end else if (pull_up_en || pull_down_en) begin
      req_pin = pull_up_en;
    end else begin
      // A floating pin is not trusted to keep its value.
      req_pin = ~req_pin;
    end
  end
endmodule

/* File: bench/epd_top_bench.sv */
// Self-checking bench for the request pin detector.
// Assumes the package register map and a one-word AXI4-Lite slave.
`timescale 1ns/10ps

module epd_top_bench;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        drv_en = 1'b1;  // Device drives the pin.
  logic        drv_val = 1'b0;
  logic        req_pin, pull_up_en, pull_down_en, cpu_req, irq;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  int          err_count = 0, num_checks = 0, cyc = 0;

  always #10 core_clk = ~core_clk;

  epd_top dut (.core_clk(core_clk), .reset(reset), .req_pin(req_pin),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .cpu_req(cpu_req), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  epd_pin_model pin_dev (.drv_en(drv_en), .drv_val(drv_val), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .req_pin(req_pin));

  // Prints the counts and the verdict, then stops.
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // One write; each channel is released at the edge it is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic a_ok, w_ok, b_ok;
    a_ok = 0;
    w_ok = 0;
    b_ok = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok) begin
      @(posedge core_clk);
      if (!a_ok && awready === 1'b1) begin
        a_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        b_ok = 1;
        bready <= 1'b0;
        chk(bresp, er);
      end
    end
    // Pads and requests launch at the answering edge, so let them settle first.
    @(negedge core_clk);
  endtask

  // One read, compared with the expected word and response.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic r_ok;
    r_ok = 0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok) begin
      @(posedge core_clk);
      if (arready === 1'b1) begin
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        r_ok = 1;
        rready <= 1'b0;
        chk(rdata, e);
        chk(rresp, er);
      end
    end
    // Callers compare outputs only after this edge has settled.
    @(negedge core_clk);
  endtask

  // Moves the pin and lets the synchroniser and flag settle.
  task automatic pin(input logic v);
    @(posedge core_clk);
    drv_val <= v;
    repeat (6) @(posedge core_clk);
  endtask

  // A hang counts as a mismatch and closes the run.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      test_done;
    end
  end

  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    rd(8'h08, 32'h0, 2'h0);
    rd(8'h0c, 32'h0, 2'h2);
    wr(8'h0c, 32'hff, 2'h2);
    rd(8'h00, 32'h0, 2'h0);
    // Rising edge mode, then acknowledge with zero and with one.
    wr(8'h00, 32'h32, 2'h0);
    chk(pull_down_en, 1'b1);
    chk(pull_up_en, 1'b0);
    pin(1'b1);
    rd(8'h00, 32'h3a, 2'h0);
    chk(cpu_req, 1'b1);
    wr(8'h00, 32'h32, 2'h0);
    rd(8'h00, 32'h3a, 2'h0);
    wr(8'h00, 32'h36, 2'h0);
    repeat (6) @(posedge core_clk);
    rd(8'h00, 32'h32, 2'h0);
    chk(cpu_req, 1'b0);
    // Falling edge mode with the pull-up.
    wr(8'h00, 32'h12, 2'h0);
    chk(pull_up_en, 1'b1);
    // Released pin must rest high on the pull-up and raise no event.
    drv_en <= 1'b0;
    pin(1'b1);
    rd(8'h00, 32'h12, 2'h0);
    chk(req_pin, 1'b1);
    drv_en <= 1'b1;
    pin(1'b0);
    rd(8'h00, 32'h1a, 2'h0);
    wr(8'h00, 32'h16, 2'h0);
    rd(8'h00, 32'h12, 2'h0);
    // Level mode keeps the flag while the pin is asserted.
    wr(8'h00, 32'h33, 2'h0);
    pin(1'b1);
    wr(8'h00, 32'h37, 2'h0);
    rd(8'h00, 32'h3b, 2'h0);
    pin(1'b0);
    wr(8'h00, 32'h37, 2'h0);
    rd(8'h00, 32'h33, 2'h0);
    // Pull disable and polled flag.
    wr(8'h00, 32'h70, 2'h0);
    chk({pull_up_en, pull_down_en}, 2'h0);
    wr(8'h00, 32'h30, 2'h0);
    pin(1'b1);
    rd(8'h00, 32'h38, 2'h0);
    chk(cpu_req, 1'b0);
    wr(8'h00, 32'h36, 2'h0);
    // Pin function off: no events at all.
    wr(8'h00, 32'h22, 2'h0);
    pin(1'b0);
    pin(1'b1);
    rd(8'h00, 32'h22, 2'h0);
    // Sticky status, mask and clearing of the gathered interrupt.
    rd(8'h04, 32'h1, 2'h0);
    chk(irq, 1'b0);
    wr(8'h08, 32'h1, 2'h0);
    rd(8'h08, 32'h1, 2'h0);
    chk(irq, 1'b1);
    wr(8'h04, 32'h1, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    chk(irq, 1'b0);
    test_done;
  end
endmodule

/* File: logic/epd_pkg.sv */
// Package for the external request pin detector: register map, field
// positions, reset values and bus response codes.
// Assumes a 32-bit AXI4-Lite register bus with byte addressing.
package epd_pkg;

  // Width of the byte address that the register slave decodes.
  localparam int unsigned ADDR_W = 8;

  // Byte offsets of the three registers, one aligned word each.
  localparam logic [7:0] OFF_CTRL     = 8'h00;  // Pin request status and control.
  localparam logic [7:0] OFF_INT_STAT = 8'h04;  // Sticky event status, write one to clear.
  localparam logic [7:0] OFF_INT_MASK = 8'h08;  // Mask of the sticky event status.

  // Field positions inside the pin request status and control register.
  localparam int unsigned BIT_PULL_DISABLE  = 6;  // Pull device off while pin enabled.
  localparam int unsigned BIT_EDGE_POLARITY = 5;  // 0 falling or low, 1 rising or high.
  localparam int unsigned BIT_PIN_ENABLE    = 4;  // Pin request function enable.
  localparam int unsigned BIT_REQ_FLAG      = 3;  // Read-only pending request flag.
  localparam int unsigned BIT_REQ_ACK       = 2;  // Write-only acknowledge, reads zero.
  localparam int unsigned BIT_REQ_INT_EN    = 1;  // Cpu interrupt request enable.
  localparam int unsigned BIT_DETECT_MODE   = 0;  // 0 edge only, 1 edge and level.

  // Field position of the request event in the sticky status and mask registers.
  localparam int unsigned BIT_EVT_REQUEST = 0;

  // Reset values of the stored control bits and of the event registers.
  localparam logic       RST_CTRL_BIT = 1'b0;
  localparam logic       RST_FLAG     = 1'b0;
  localparam logic [0:0] RST_INT_STAT = 1'h0;
  localparam logic [0:0] RST_INT_MASK = 1'h0;

  // Default number of synchroniser stages on the request pin.
  localparam int unsigned SYNC_STAGES_DEF = 2;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: logic/epd_sync.sv */
// Level synchroniser for one asynchronous input bit.
// Assumes its input is a pin or another clock's signal; its output is the
// last stage of a plain flip-flop chain and is safe for any logic to read.
`timescale 1ns/10ps

module epd_sync #(
  parameter int unsigned STAGES = 2
) (
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic reset,
  // Asynchronous input and synchronised output.
  input  wire logic async_in,
  output logic      sync_out
);

  // Refuse a chain too short to settle metastability.
  generate
    if (STAGES < 2) begin : g_chk
      $error("epd_sync needs at least two stages.");
    end
  endgenerate

  // The stage chain; only the next stage ever reads a stage before the last.
  logic [STAGES-1:0] stage_q;

  // Shift the pin in on every edge; cleared by the synchronous reset.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      stage_q <= '0;
    end else begin
      stage_q <= {stage_q[STAGES-2:0], async_in};
    end
  end

  // The oldest stage is the settled copy of the input.
  assign sync_out = stage_q[STAGES-1];

endmodule

/* File: logic/epd_top.sv */
// External interrupt request pin detector with an AXI4-Lite register slave.
// Assumes one 50 MHz core clock, a synchronous active-high reset, and a
// request pin that may change at any time relative to the clock.
//
// Functional notes
// - Pull disable bit turns pull device off.
// - Polarity bit chooses falling/low or rising/high.
// - Pull-down for rising, pull-up for falling.
// - Pin enable gates all event detection.
// - Request flag set by qualifying pin event.
// - Writing acknowledge one clears the flag.
// - Acknowledge zero ignored; acknowledge reads zero.
// - Level mode keeps flag while pin asserted.
// - Interrupt enable gates cpu request from flag.
// - Edge mode: only edges set the flag.
// - Level mode: edge or held level sets.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps

module epd_top #(
  parameter int unsigned SYNC_STAGES = epd_pkg::SYNC_STAGES_DEF
) (
  // Clock and reset.
  input  wire logic                       core_clk,
  input  wire logic                       reset,
  // External request pin.
  input  wire logic                       req_pin,
  // Pull device controls for the request pin pad.
  output logic                            pull_up_en,
  output logic                            pull_down_en,
  // Cpu interrupt request and gathered event interrupt.
  output logic                            cpu_req,
  output logic                            irq,
  // AXI4-Lite write address channel.
  input  wire logic [epd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  // AXI4-Lite write data channel.
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read address channel.
  input  wire logic [epd_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready
);

  // Refuse parameter values that the pin path cannot serve.
  generate
    if (SYNC_STAGES < 2) begin : g_chk
      $error("epd_top needs at least two synchroniser stages.");
    end
  endgenerate

  // Stored control bits of the pin request register.
  logic pull_disable_q;      // Pull device off while the pin is enabled.
  logic edge_polarity_q;     // Chosen sensitivity polarity.
  logic pin_enable_q;        // Pin request function enable.
  logic req_int_en_q;        // Cpu interrupt request enable.
  logic detect_mode_q;       // Edge only or edge and level.
  logic req_flag_q;          // Pending request flag.
  logic req_flag_d;          // Next value of the pending flag.

  // Sticky event status, its mask and the registered outputs.
  logic int_stat_q;          // Sticky record of request events.
  logic int_stat_d;          // Next value of the sticky record.
  logic int_mask_q;          // Enable of the sticky record onto irq.
  logic pull_up_q;           // Registered pull-up control.
  logic pull_down_q;         // Registered pull-down control.
  logic cpu_req_q;           // Registered cpu request.
  logic irq_q;               // Registered gathered interrupt.

  // Pin path signals.
  logic pin_sync;            // Settled copy of the pin.
  logic pin_prev_q;          // Previous settled sample of the pin.
  logic pin_asserted;        // Pin sits at the chosen active level.
  logic pin_edge;            // Pin has just moved to the active level.
  logic req_event;           // Qualifying request event this cycle.

  // Write path state.
  logic                      aw_have_q;   // Write address held.
  logic                      w_have_q;    // Write data held.
  logic [epd_pkg::ADDR_W-1:0] aw_addr_q;  // Held write address.
  logic [31:0]               w_data_q;    // Held write data.
  logic [3:0]                w_strb_q;    // Held write strobes.
  logic                      awready_q;   // Write address ready.
  logic                      wready_q;    // Write data ready.
  logic                      bvalid_q;    // Write response valid.
  logic [1:0]                bresp_q;     // Write response code.

  // Read path state.
  logic                      arready_q;   // Read address ready.
  logic                      rvalid_q;    // Read data valid.
  logic [31:0]               rdata_q;     // Read data word.
  logic [1:0]                rresp_q;     // Read response code.

  // Synchronise the asynchronous pin before any logic reads it.
  epd_sync #(
    .STAGES   (SYNC_STAGES)
  ) u_pin_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in (req_pin),
    .sync_out (pin_sync)
  );

  // Edge and level detection. The previous sample follows the pin even while
  // the function is off, so enabling it never fakes an edge from stale state.
  // compare consecutive samples
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_sync;
    end
  end

  assign pin_asserted = edge_polarity_q ? pin_sync : ~pin_sync;
  assign pin_edge     = edge_polarity_q ? (pin_sync & ~pin_prev_q) : (~pin_sync & pin_prev_q);
  assign req_event    = pin_enable_q & (pin_edge | (detect_mode_q & pin_asserted));

  // Write handshakes and the single write stroke, taken once both halves
  // are held and no response is outstanding.
  logic                       aw_take;
  logic                       w_take;
  logic                       do_write;
  logic                       aw_have_d;
  logic                       w_have_d;
  logic                       bvalid_d;
  logic [epd_pkg::ADDR_W-1:0] wr_word;
  logic                       wr_ctrl;
  logic                       wr_stat;
  logic                       wr_mask;
  logic                       wr_hit;
  logic                       wr_lane0;

  assign aw_take   = s_axi_awvalid & awready_q;
  assign w_take    = s_axi_wvalid & wready_q;
  assign do_write  = aw_have_q & w_have_q & ~bvalid_q;
  assign aw_have_d = (aw_have_q | aw_take) & ~do_write;
  assign w_have_d  = (w_have_q | w_take) & ~do_write;
  assign bvalid_d  = do_write | (bvalid_q & ~s_axi_bready);

  // Address decode of the held write address, word aligned.
  assign wr_word  = {aw_addr_q[epd_pkg::ADDR_W-1:2], 2'h0};
  assign wr_ctrl  = do_write & (wr_word == epd_pkg::OFF_CTRL);
  assign wr_stat  = do_write & (wr_word == epd_pkg::OFF_INT_STAT);
  assign wr_mask  = do_write & (wr_word == epd_pkg::OFF_INT_MASK);
  assign wr_hit   = wr_ctrl | wr_stat | wr_mask;
  assign wr_lane0 = w_strb_q[0];

  // Acknowledge only on a one in the ack bit; a zero there touches nothing.
  logic ack_clear;
  assign ack_clear = wr_ctrl & wr_lane0 & w_data_q[epd_pkg::BIT_REQ_ACK];

  // The event wins over an acknowledge in the same cycle. In level mode the
  // held level raises an event every cycle, so the flag cannot be cleared
  // until the pin lets go.
  // event sets flag
  assign req_flag_d = req_event | (req_flag_q & ~ack_clear);

  // Sticky event record: a new event beats a write-one clear.
  logic stat_clear;
  assign stat_clear = wr_stat & wr_lane0 & w_data_q[epd_pkg::BIT_EVT_REQUEST];
  assign int_stat_d = req_event | (int_stat_q & ~stat_clear);

  // Write channel registers; ready drops while a half is held or answered.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= epd_pkg::RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awready_q <= ~aw_have_d & ~bvalid_d;
      wready_q  <= ~w_have_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
      if (do_write) begin
        bresp_q <= wr_hit ? epd_pkg::RESP_OKAY : epd_pkg::RESP_SLVERR;
      end
    end
  end

  // Capture the address and data halves as each one is taken.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end else begin
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // Control bits of the pin request register, written through byte lane 0.
  // control cleared at reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pull_disable_q  <= epd_pkg::RST_CTRL_BIT;
      edge_polarity_q <= epd_pkg::RST_CTRL_BIT;
      pin_enable_q    <= epd_pkg::RST_CTRL_BIT;
      req_int_en_q    <= epd_pkg::RST_CTRL_BIT;
      detect_mode_q   <= epd_pkg::RST_CTRL_BIT;
    end else if (wr_ctrl && wr_lane0) begin
      pull_disable_q  <= w_data_q[epd_pkg::BIT_PULL_DISABLE];
      edge_polarity_q <= w_data_q[epd_pkg::BIT_EDGE_POLARITY];
      pin_enable_q    <= w_data_q[epd_pkg::BIT_PIN_ENABLE];
      req_int_en_q    <= w_data_q[epd_pkg::BIT_REQ_INT_EN];
      detect_mode_q   <= w_data_q[epd_pkg::BIT_DETECT_MODE];
    end
  end

  // Flag, event record and mask.
  // flag cleared at reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      req_flag_q <= epd_pkg::RST_FLAG;
      int_stat_q <= epd_pkg::RST_INT_STAT[0];
      int_mask_q <= epd_pkg::RST_INT_MASK[0];
    end else begin
      req_flag_q <= req_flag_d;
      int_stat_q <= int_stat_d;
      if (wr_mask && wr_lane0) begin
        int_mask_q <= w_data_q[epd_pkg::BIT_EVT_REQUEST];
      end
    end
  end

  // Pad controls and interrupt outputs. The pull device follows polarity so
  // that an idle pin rests at its inactive level; with pull disable set an
  // outside resistor must hold it instead.
  logic pull_on;
  assign pull_on = pin_enable_q & ~pull_disable_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pull_up_q   <= 1'b0;
      pull_down_q <= 1'b0;
      cpu_req_q   <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      pull_up_q   <= pull_on & ~edge_polarity_q;
      pull_down_q <= pull_on & edge_polarity_q;
      cpu_req_q   <= req_flag_d & req_int_en_q;
      irq_q       <= int_stat_d & int_mask_q;
    end
  end

  // Read path: one read at a time, answered the cycle after the address.
  logic                       ar_take;
  logic                       rvalid_d;
  logic [epd_pkg::ADDR_W-1:0] rd_word;
  logic                       rd_ctrl;
  logic                       rd_stat;
  logic                       rd_mask;
  logic [31:0]                ctrl_word;
  logic [31:0]                rd_value;

  assign ar_take  = s_axi_arvalid & arready_q;
  assign rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
  assign rd_word  = {s_axi_araddr[epd_pkg::ADDR_W-1:2], 2'h0};
  assign rd_ctrl  = rd_word == epd_pkg::OFF_CTRL;
  assign rd_stat  = rd_word == epd_pkg::OFF_INT_STAT;
  assign rd_mask  = rd_word == epd_pkg::OFF_INT_MASK;

  // Assemble the control word; reserved bit 7 and the ack bit read zero.
  // ack reads zero
  always_comb begin
    ctrl_word = 32'h0;
    ctrl_word[epd_pkg::BIT_PULL_DISABLE]  = pull_disable_q;
    ctrl_word[epd_pkg::BIT_EDGE_POLARITY] = edge_polarity_q;
    ctrl_word[epd_pkg::BIT_PIN_ENABLE]    = pin_enable_q;
    ctrl_word[epd_pkg::BIT_REQ_FLAG]      = req_flag_q;
    ctrl_word[epd_pkg::BIT_REQ_INT_EN]    = req_int_en_q;
    ctrl_word[epd_pkg::BIT_DETECT_MODE]   = detect_mode_q;
  end

  // Read selection; an unmapped word reads zero with an error response.
  assign rd_value = rd_ctrl ? ctrl_word :
                    rd_stat ? {31'h0, int_stat_q} :
                    rd_mask ? {31'h0, int_mask_q} : 32'h0;

  // Read channel registers.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= epd_pkg::RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_value;
        rresp_q <= (rd_ctrl | rd_stat | rd_mask) ? epd_pkg::RESP_OKAY : epd_pkg::RESP_SLVERR;
      end
    end
  end

  // Every output comes straight from a flip-flop.
  assign pull_up_en    = pull_up_q;
  assign pull_down_en  = pull_down_q;
  assign cpu_req       = cpu_req_q;
  assign irq           = irq_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

endmodule
